/* File: emulated_phy_asserts.sv */
`timescale 1ns/1ps
module emulated_phy_asserts (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic memSel,
    input wire logic memWrite,
    input wire logic [8:0] memAddr,
    input wire logic [31:0] memRdata,
    input wire logic mgmtSel,
    input wire logic [4:0] mgmtPhyAddr,
    input wire logic [4:0] mgmtRegIndex,
    input wire logic [4:0] phyAddrStrap,
    input wire logic [15:0] mgmtRdata,
    input wire logic mgmtAck,
    input wire logic hostTxEn,
    input wire logic hostCol,
    input wire logic linkSpeed100,
    input wire logic linkFullDuplex,
    input wire logic autonegRefresh
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_pad_zero: assert property (memRdata[31:16] == 16'h0 && memRdata[6:0] == 7'h0) else $error("pad set");
    a_status_mem: assert property (memSel && !memWrite && memAddr == 9'h1c4 |=> memRdata == 32'h7800)
        else $error("status view wrong");
    a_mgmt_hit: assert property (mgmtSel && mgmtPhyAddr == phyAddrStrap |=> mgmtAck) else $error("no ack");
    a_mgmt_miss: assert property (!(mgmtSel && mgmtPhyAddr == phyAddrStrap) |=> !mgmtAck) else $error("stray ack");
    a_status_mgmt: assert property (mgmtSel && mgmtPhyAddr == phyAddrStrap && mgmtRegIndex == 5'h01
        |=> mgmtRdata == 16'h7800) else $error("status index wrong");
    a_autoneg_link: assert property (mgmtAck && $past(mgmtRegIndex) == 5'h00 && mgmtRdata[12]
        |-> linkSpeed100 && linkFullDuplex) else $error("autoneg link wrong");
    a_forced_link: assert property (mgmtAck && $past(mgmtRegIndex) == 5'h00 && !mgmtRdata[12]
        |-> {linkSpeed100, linkFullDuplex} == {mgmtRdata[13], mgmtRdata[8]}) else $error("forced link wrong");
    a_col_tx: assert property (hostCol |-> $past(hostTxEn)) else $error("collision without tx");
    a_refresh_pulse: assert property (autonegRefresh |=> !autonegRefresh) else $error("refresh too long");
endmodule // emulated_phy_asserts

/* File: emulated_phy_ctrl_status.sv */
`timescale 1ns/1ps
module emulated_phy_ctrl_status #(
    parameter int STRAP_RESET_CYCLES = emulated_phy_pkg::STRAP_RESET_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic memSel,
    input wire logic memWrite,
    input wire logic [8:0] memAddr,
    input wire logic [31:0] memWdata,
    output logic [31:0] memRdata,
    input wire logic mgmtSel,
    input wire logic mgmtWrite,
    input wire logic [4:0] mgmtPhyAddr,
    input wire logic [4:0] mgmtRegIndex,
    input wire logic [15:0] mgmtWdata,
    output logic [15:0] mgmtRdata,
    output logic mgmtAck,
    input wire logic [4:0] phyAddrStrap,
    input wire logic chipPhyResetSet,
    output logic chipPhyResetBusy,
    input wire logic hostTxEn,
    input wire logic [3:0] hostTxData,
    input wire logic [3:0] fabricRxData,
    input wire logic fabricRxValid,
    output logic [3:0] hostRxData,
    output logic hostRxValid,
    output logic [3:0] fabricTxData,
    output logic fabricTxEn,
    output logic hostCol,
    output logic linkSpeed100,
    output logic linkFullDuplex,
    output logic autonegRefresh
);
    logic [15:0] ctrl_r;
    logic [15:0] ctrl_nxt;
    logic refresh_r;
    logic refresh_nxt;
    logic [15:0] memRdata_r;
    logic [15:0] memRdata_nxt;
    logic [15:0] mgmtRdata_r;
    logic [15:0] mgmtRdata_nxt;
    logic mgmtAck_r;
    logic mgmtAck_nxt;
    logic [4:0] strapMeta_r;
    logic [4:0] strapSync_r;
    logic [4:0] strap_r;
    logic [4:0] strap_nxt;
    logic strapTaken_r;
    logic strapTaken_nxt;
    logic [3:0] hostRxData_r;
    logic [3:0] hostRxData_nxt;
    logic hostRxValid_r;
    logic hostRxValid_nxt;
    logic [3:0] fabricTxData_r;
    logic [3:0] fabricTxData_nxt;
    logic fabricTxEn_r;
    logic fabricTxEn_nxt;
    logic hostCol_r;
    logic hostCol_nxt;
    logic linkSpeed100_r;
    logic linkSpeed100_nxt;
    logic linkFullDuplex_r;
    logic linkFullDuplex_nxt;
    logic timerDone;
    logic memHitCtrl;
    logic memHitStatus;
    logic mgmtIsCtrl;
    logic mgmtIsStatus;
    logic mgmtHit;
    logic memCtrlWrite;
    logic mgmtCtrlWrite;
    logic softReset;
    logic restartReq;

    // shared read view, also used for management reads
    function automatic logic [15:0] read_view(
        input logic [15:0] ctrl,
        input logic isCtrl,
        input logic isStatus
    );
        logic [15:0] v;
        v = 16'h0000;
        if (isCtrl) begin
            v = ctrl & emulated_phy_pkg::CTRL_WRITE_MASK;
        end else if (isStatus) begin
            v = emulated_phy_pkg::STATUS_VALUE;
        end
        return v;
    endfunction

    // bit 6 and bits 5:0 hold no storage, so a written one never sticks there
    function automatic logic [15:0] write_view(input logic [15:0] data);
        return data & emulated_phy_pkg::CTRL_WRITE_MASK;
    endfunction

    // chip-level reset request: its end restores the same defaults as a soft reset
    reset_timer #(
        .CYCLES(STRAP_RESET_CYCLES)
    ) u_reset_timer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .start(chipPhyResetSet),
        .busy(chipPhyResetBusy),
        .done(timerDone)
    );

    assign memHitCtrl = memAddr == emulated_phy_pkg::CTRL_OFFSET;
    assign memHitStatus = memAddr == emulated_phy_pkg::STATUS_OFFSET;
    assign mgmtIsCtrl = mgmtRegIndex == emulated_phy_pkg::CTRL_INDEX;
    assign mgmtIsStatus = mgmtRegIndex == emulated_phy_pkg::STATUS_INDEX;
    // strap is caught after reset release, never in the reset branch itself
    assign mgmtHit = mgmtSel && strapTaken_r && (mgmtPhyAddr == strap_r);
    // writes to the status offset or to unmapped places fall through with no effect
    assign memCtrlWrite = memSel && memWrite && memHitCtrl;
    assign mgmtCtrlWrite = mgmtHit && mgmtWrite && mgmtIsCtrl;
    assign softReset = ctrl_r[emulated_phy_pkg::RESET_BIT] || timerDone;
    assign restartReq = ctrl_r[emulated_phy_pkg::RESTART_BIT];

    // the strap pins are not timed to sys_clk; the synchroniser runs through reset so it is full at release
    always_ff @(posedge sys_clk) begin
        strapMeta_r <= phyAddrStrap;
        strapSync_r <= strapMeta_r;
    end

    // the strap is sampled once; a later change needs rst_n, since the chip-level reset request does not resample it
    always_comb begin
        strap_nxt = strap_r;
        strapTaken_nxt = 1'b1;
        if (!strapTaken_r) begin
            strap_nxt = strapSync_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            strap_r <= 5'h00;
            strapTaken_r <= 1'b0;
        end else begin
            strap_r <= strap_nxt;
            strapTaken_r <= strapTaken_nxt;
        end
    end

    always_comb begin
        ctrl_nxt = ctrl_r;
        refresh_nxt = 1'b0;
        // a restart request is served in one cycle, so it reads back zero once that cycle has passed
        if (restartReq) begin
            ctrl_nxt[emulated_phy_pkg::RESTART_BIT] = 1'b0;
            refresh_nxt = 1'b1;
        end
        // memory writes keep only the low half; the upper half is padding
        if (memCtrlWrite) begin
            ctrl_nxt = write_view(memWdata[15:0]);
        end
        // management is applied last, so it wins a collision with a memory write
        if (mgmtCtrlWrite) begin
            ctrl_nxt = write_view(mgmtWdata);
        end
        // soft reset beats any simultaneous write: defaults land and the bit reads zero
        if (softReset) begin
            ctrl_nxt = emulated_phy_pkg::CTRL_RESET;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_r <= emulated_phy_pkg::CTRL_RESET;
            refresh_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            refresh_r <= refresh_nxt;
        end
    end

    // read data holds until the next access on its own bus
    always_comb begin
        memRdata_nxt = memRdata_r;
        mgmtRdata_nxt = mgmtRdata_r;
        mgmtAck_nxt = 1'b0;
        if (memSel) begin
            memRdata_nxt = read_view(ctrl_r, memHitCtrl, memHitStatus);
        end
        if (mgmtHit) begin
            mgmtAck_nxt = 1'b1;
            mgmtRdata_nxt = read_view(ctrl_r, mgmtIsCtrl, mgmtIsStatus);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            memRdata_r <= 16'h0000;
            mgmtRdata_r <= 16'h0000;
            mgmtAck_r <= 1'b0;
        end else begin
            memRdata_r <= memRdata_nxt;
            mgmtRdata_r <= mgmtRdata_nxt;
            mgmtAck_r <= mgmtAck_nxt;
        end
    end

    // receive side: fabric traffic, or the host's own frames while looped back
    always_comb begin
        hostRxData_nxt = fabricRxData;
        hostRxValid_nxt = fabricRxValid;
        if (ctrl_r[emulated_phy_pkg::LOOPBACK_BIT]) begin
            hostRxData_nxt = hostTxData;
            hostRxValid_nxt = hostTxEn;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            hostRxData_r <= 4'h0;
            hostRxValid_r <= 1'b0;
        end else begin
            hostRxData_r <= hostRxData_nxt;
            hostRxValid_r <= hostRxValid_nxt;
        end
    end

    // transmit side; collision test is not gated by loopback, software must pair them
    always_comb begin
        fabricTxData_nxt = hostTxData;
        fabricTxEn_nxt = hostTxEn;
        if (ctrl_r[emulated_phy_pkg::LOOPBACK_BIT]) begin
            // while looped back the fabric sees an idle, silent port
            fabricTxData_nxt = 4'h0;
            fabricTxEn_nxt = 1'b0;
        end
        // collision follows transmit enable with the same one-cycle latency as the data
        hostCol_nxt = ctrl_r[emulated_phy_pkg::COLTEST_BIT] && hostTxEn;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            fabricTxData_r <= 4'h0;
            fabricTxEn_r <= 1'b0;
            hostCol_r <= 1'b0;
        end else begin
            fabricTxData_r <= fabricTxData_nxt;
            fabricTxEn_r <= fabricTxEn_nxt;
            hostCol_r <= hostCol_nxt;
        end
    end

    // no negotiation is emulated; with autoneg on the link pins report 100 Mb/s full duplex
    always_comb begin
        linkSpeed100_nxt = 1'b1;
        linkFullDuplex_nxt = 1'b1;
        if (!ctrl_r[emulated_phy_pkg::AUTONEG_BIT]) begin
            linkSpeed100_nxt = ctrl_r[emulated_phy_pkg::SPEED_BIT];
            linkFullDuplex_nxt = ctrl_r[emulated_phy_pkg::DUPLEX_BIT];
        end
    end

    // registered so the link pins follow a control write one cycle late, never mid-cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            linkSpeed100_r <= 1'b1;
            linkFullDuplex_r <= 1'b1;
        end else begin
            linkSpeed100_r <= linkSpeed100_nxt;
            linkFullDuplex_r <= linkFullDuplex_nxt;
        end
    end

    // every output below comes straight from a register, except the upper half of memRdata, which is tied to zero
    assign memRdata = {16'h0000, memRdata_r};
    assign mgmtRdata = mgmtRdata_r;
    assign mgmtAck = mgmtAck_r;
    assign autonegRefresh = refresh_r;
    assign hostRxData = hostRxData_r;
    assign hostRxValid = hostRxValid_r;
    assign fabricTxData = fabricTxData_r;
    assign fabricTxEn = fabricTxEn_r;
    assign hostCol = hostCol_r;
    assign linkSpeed100 = linkSpeed100_r;
    assign linkFullDuplex = linkFullDuplex_r;
endmodule // emulated_phy_ctrl_status

/* File: emulated_phy_pkg.sv */
package emulated_phy_pkg;
    localparam logic [8:0] CTRL_OFFSET = 9'h1c0;
    localparam logic [8:0] STATUS_OFFSET = 9'h1c4;
    localparam logic [4:0] CTRL_INDEX = 5'h00;
    localparam logic [4:0] STATUS_INDEX = 5'h01;
    localparam int RESET_BIT = 15;
    localparam int LOOPBACK_BIT = 14;
    localparam int SPEED_BIT = 13;
    localparam int AUTONEG_BIT = 12;
    localparam int POWER_DOWN_BIT = 11;
    localparam int ISOLATE_BIT = 10;
    localparam int RESTART_BIT = 9;
    localparam int DUPLEX_BIT = 8;
    localparam int COLTEST_BIT = 7;
    localparam logic [15:0] CTRL_RESET = 16'h1000;
    localparam logic [15:0] CTRL_WRITE_MASK = 16'hff80;
    localparam logic [15:0] STATUS_VALUE = 16'h7800;
    localparam int CLOCK_MHZ = 200;
    localparam int STRAP_RESET_US = 102;
    localparam int STRAP_RESET_CYCLES = STRAP_RESET_US * CLOCK_MHZ;
endpackage

/* File: mac_model.sv */
`timescale 1ns/1ps
// host mac transmit side: random bursts, idle gaps carry junk data
module mac_model (
    input wire logic sys_clk,
    output logic hostTxEn,
    output logic [3:0] hostTxData
);
    initial begin
        {hostTxEn, hostTxData} = 5'h00;
        forever begin
            @(posedge sys_clk);
            #1 hostTxEn = ($urandom % 3) != 0;
            hostTxData = 4'($urandom);
        end
    end
endmodule // mac_model

/* File: reset_timer.sv */
`timescale 1ns/1ps
// counts a fixed span after a start pulse; done is a one-cycle pulse
module reset_timer #(
    parameter int CYCLES = 20400
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic start,
    output logic busy,
    output logic done
);
    logic [31:0] count_r;
    logic [31:0] count_nxt;
    logic busy_r;
    logic busy_nxt;
    logic done_r;
    logic done_nxt;

    always_comb begin
        count_nxt = count_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        if (start) begin
            busy_nxt = 1'b1;
            count_nxt = 32'h0;
        end else if (busy_r) begin
            if (count_r == 32'(CYCLES - 1)) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end else begin
                count_nxt = count_r + 32'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            count_r <= 32'h0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end

    assign busy = busy_r;
    assign done = done_r;
endmodule // reset_timer

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
    logic sys_clk, rst_n, memSel, memWrite, mgmtSel, mgmtWrite, chipPhyResetSet, fabricRxValid, mgmtAck;
    logic chipPhyResetBusy, hostTxEn, hostRxValid, fabricTxEn, hostCol, linkSpeed100, linkFullDuplex, autonegRefresh;
    logic [8:0] memAddr;
    logic [31:0] memWdata, memRdata;
    logic [4:0] mgmtPhyAddr, mgmtRegIndex;
    logic [4:0] phyAddrStrap = 5'h0b;
    logic [15:0] mgmtWdata, mgmtRdata, w;
    logic [3:0] fabricRxData, hostRxData, fabricTxData, hostTxData;
    int fails = 0;
    int check_count = 0;
    int refreshCount = 0;
    int refreshExp = 0;
    emulated_phy_ctrl_status #(.STRAP_RESET_CYCLES(20)) emulated_phy_ctrl_status_inst (.*);
    mac_model mac_model_inst (.*);
    always @(posedge sys_clk) begin
        if (rst_n && autonegRefresh) refreshCount++;
    end
    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic report_and_stop;
        if (fails == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // writes wait two extra edges so self-clearing bits have settled
    task automatic mem(logic wr, logic [8:0] a, logic [31:0] d);
        @(posedge sys_clk);
        #1 {memSel, memWrite, memAddr, memWdata} = {1'b1, wr, a, d};
        @(posedge sys_clk);
        #1 memSel = 1'b0;
        if (wr) repeat (2) @(posedge sys_clk);
    endtask
    task automatic mgmt(logic wr, logic [4:0] pa, logic [4:0] idx, logic [15:0] d, logic ack);
        @(posedge sys_clk);
        #1 {mgmtSel, mgmtWrite, mgmtPhyAddr, mgmtRegIndex, mgmtWdata} = {1'b1, wr, pa, idx, d};
        @(posedge sys_clk);
        #1 mgmtSel = 1'b0;
        chk("mgmtAck", 32'(ack), 32'(mgmtAck));
        if (wr) repeat (2) @(posedge sys_clk);
    endtask
    task automatic rd(logic [15:0] exp, logic [8:0] a, logic [4:0] idx);
        mem(1'b0, a, 32'h0);
        chk("memRdata", {16'h0, exp}, memRdata);
        mgmt(1'b0, phyAddrStrap, idx, 16'h0, 1'b1);
        chk("mgmtRdata", 32'(exp), 32'(mgmtRdata));
    endtask
    function automatic logic [15:0] ctrlAfter(logic [15:0] v);
        return v[15] ? 16'h1000 : v & 16'h7d80;
    endfunction
    task automatic path(logic lb, logic col);
        logic en, fv;
        logic [3:0] d, fd;
        repeat (24) begin
            @(posedge sys_clk);
            {en, d, fv, fd} = {hostTxEn, hostTxData, fabricRxValid, fabricRxData};
            #1 {fabricRxValid, fabricRxData} = 5'($urandom);
            chk("hostRx", lb ? {en, d & {4{en}}} : {fv, fd & {4{fv}}}, {hostRxValid, hostRxData & {4{hostRxValid}}});
            chk("fabricTx", {~lb & en, d & {4{~lb & en}}}, {fabricTxEn, fabricTxData & {4{fabricTxEn}}});
            chk("hostCol", 32'(col & en), 32'(hostCol));
        end
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        {rst_n, memSel, memWrite, mgmtSel, mgmtWrite, chipPhyResetSet, fabricRxValid} = 7'h00;
        {memAddr, memWdata, mgmtPhyAddr, mgmtRegIndex, mgmtWdata, fabricRxData} = '0;
        void'($urandom(32'h69c5));
        repeat (12) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 chk("link", 32'h3, 32'({linkSpeed100, linkFullDuplex}));
        rd(16'h1000, 9'h1c0, 5'h00);
        rd(16'h0000, 9'h1c8, 5'h02);
        mem(1'b1, 9'h1c4, 32'hffffffff);
        rd(16'h7800, 9'h1c4, 5'h01);
        mgmt(1'b1, phyAddrStrap ^ 5'h04, 5'h00, 16'h4000, 1'b0);
        rd(16'h1000, 9'h1c0, 5'h00);
        for (int i = 0; i < 12; i++) begin
            w = i < 2 ? 16'hffff >> i : 16'($urandom);
            if (w[9]) refreshExp++;
            if (i[0]) mgmt(1'b1, phyAddrStrap, 5'h00, w, 1'b1);
            else mem(1'b1, 9'h1c0, {16'hffff, w});
            rd(ctrlAfter(w), 9'h1c0, 5'h00);
        end
        mem(1'b1, 9'h1c0, 32'h2100);
        #1 chk("link", 32'h3, 32'({linkSpeed100, linkFullDuplex}));
        path(1'b0, 1'b0);
        mem(1'b1, 9'h1c0, 32'h4080);
        #1 chk("link", 32'h0, 32'({linkSpeed100, linkFullDuplex}));
        path(1'b1, 1'b1);
        mem(1'b1, 9'h1c0, 32'h8000);
        rd(16'h1000, 9'h1c0, 5'h00);
        chk("link", 32'h3, 32'({linkSpeed100, linkFullDuplex}));
        mem(1'b1, 9'h1c0, 32'h4000);
        #1 chipPhyResetSet = 1'b1;
        @(posedge sys_clk);
        #1 chipPhyResetSet = 1'b0;
        chk("chipPhyResetBusy", 32'h1, 32'(chipPhyResetBusy));
        for (int n = 0; n < 40 && chipPhyResetBusy; n++) begin
            @(posedge sys_clk);
            #1;
        end
        chk("chipPhyResetBusy", 32'h0, 32'(chipPhyResetBusy));
        rd(16'h1000, 9'h1c0, 5'h00);
        chk("autonegRefresh", 32'(refreshExp), 32'(refreshCount));
        report_and_stop();
    end
endmodule // tb
bind emulated_phy_ctrl_status emulated_phy_asserts emulated_phy_asserts_inst (.*);
